/* logic/cbg_sequencer.sv */
// burst gate and burst phase sequencer, one subcarrier clock domain
// assumes sync, flag and select pins are asynchronous; pad logic resolves stdSel
// Operation
// - ntsc burst starts 18 counts after edge
// - ntsc burst lasts exactly nine cycles
// - counter restarts on resampled sync, one-count jitter
// - pal burst starts 24 counts after edge
// - pal burst lasts ten cycles
// - chosen gate envelope goes to colour paths
// - external flag high gives burst, low stops
// - flag held low suppresses internal burst
// - pal: b-y negative, r-y on, r-y sign alternates
// - pal: open select enables toggle, drives squarewave
// - ntsc: negative envelope on b-y only
// - resampled sync resets nine-bit counter
// - standard from divide-by-256 bit per line
// - edges before half line are ignored
`timescale 1ns/1ps
module cbg_sequencer (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic ce,
   input wire logic syncIn,
   input wire logic flagIn,
   input wire logic flagDriven,
   input wire logic stdSelIn,
   input wire logic stdGrounded,
   output logic stdSelOut,
   output logic stdSelOe,
   output logic burstGate,
   output cbg_pkg::cbg_env_t envOut,
   output logic palMode
);
   import cbg_pkg::*;

   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic armed;
      logic palMode;
      logic toggle;
      logic prevSync;
      logic [1:0] outHist;
      logic [CNT_W-1:0] gateRun;
      cbg_env_t env;
   } cbg_state_t;

   cbg_state_t st;
   cbg_state_t next_st;
   cbg_pins_t pinsS;
   logic syncEdge;
   logic validEdge;
   logic toggleEn;
   logic intGate;
   logic gate;

   function automatic logic inWindow(input logic [CNT_W-1:0] c, input logic pal);
      logic [CNT_W-1:0] s;
      logic [CNT_W-1:0] e;
      s = pal ? PAL_START : NTSC_START;
      e = pal ? PAL_START + PAL_LEN : NTSC_START + NTSC_LEN;
      return (c >= s) && (c < e);
   endfunction

   cbg_sync2 u_sync (
      .mclk(mclk),
      .arst_n(arst_n),
      .ce(ce),
      .pinsIn({syncIn, flagIn, flagDriven, stdSelIn, stdGrounded}),
      .pinsOut(pinsS)
   );

   always_comb begin
      next_st = st;
      syncEdge = pinsS.syncIn && !st.prevSync;
      validEdge = syncEdge && (st.cnt >= (st.palMode ? PAL_HALF : NTSC_HALF));
      toggleEn = st.palMode && !pinsS.stdGrounded;
      intGate = 1'b0;
      gate = 1'b0;
      if (ce) begin
         next_st.prevSync = pinsS.syncIn;
         // driven level history, matches synchroniser latency
         next_st.outHist = {st.outHist[0], st.toggle};
         if (validEdge) begin
            next_st.cnt = CNT_ZERO;
            next_st.armed = 1'b1;
            if (st.armed) begin
               next_st.palMode = st.cnt[DIV256_BIT];
            end
            if (toggleEn) begin
               next_st.toggle = !st.toggle;
            end
         end else if (st.cnt != CNT_MAX) begin
            next_st.cnt = st.cnt + CNT_ONE;
         end
         // only a low read while our own high has reached the synchroniser
         if (toggleEn && st.toggle && st.outHist[1] && !pinsS.stdSelIn) begin
            next_st.toggle = !st.toggle;
         end
         intGate = next_st.armed && inWindow(next_st.cnt, next_st.palMode);
         gate = pinsS.flagDriven ? pinsS.flagIn : intGate;
         next_st.env.byNeg = gate;
         next_st.env.ryOn = gate && next_st.palMode;
         next_st.env.ryNeg = gate && next_st.palMode && !next_st.toggle;
         // run length of the gate, for the length checks
         if (!gate) begin
            next_st.gateRun = CNT_ZERO;
         end else if (!st.env.byNeg) begin
            next_st.gateRun = CNT_ONE;
         end else if (st.gateRun != CNT_MAX) begin
            next_st.gateRun = st.gateRun + CNT_ONE;
         end
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         st <= {CNT_MAX, 1'b0, 1'b0, TOGGLE_RST, 1'b0, 2'b00, CNT_ZERO, ENV_RST};
      end else begin
         st <= next_st;
      end
   end

   assign stdSelOut = st.toggle;
   assign stdSelOe = toggleEn;
   assign burstGate = st.env.byNeg;
   assign envOut = st.env;
   assign palMode = st.palMode;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);

   a_cnt_restart: assert property (ce && validEdge |=> st.cnt == CNT_ZERO)
      else $error("counter not restarted on sync edge");
   a_half_ignore: assert property (ce && syncEdge && !validEdge |=> st.cnt != CNT_ZERO)
      else $error("early sync edge restarted counter");
   a_std_decide: assert property (ce && validEdge && st.armed
      |=> st.palMode == $past(st.cnt[DIV256_BIT]))
      else $error("standard not taken from divide-by-256 bit");
   a_ntsc_start: assert property ($rose(burstGate) && !pinsS.flagDriven && !st.palMode
      |-> st.cnt == NTSC_START)
      else $error("ntsc burst started at wrong count");
   a_ntsc_length: assert property ($fell(burstGate) && !pinsS.flagDriven && !st.palMode
      |-> $past(st.gateRun) == NTSC_LEN)
      else $error("ntsc burst not nine cycles");
   a_pal_start: assert property ($rose(burstGate) && !pinsS.flagDriven && st.palMode
      |-> st.cnt == PAL_START)
      else $error("pal burst started at wrong count");
   a_pal_length: assert property ($fell(burstGate) && !pinsS.flagDriven && st.palMode
      |-> $past(st.gateRun) == PAL_LEN)
      else $error("pal burst not ten cycles");
   a_gate_armed: assert property (burstGate && !pinsS.flagDriven |-> st.armed)
      else $error("internal burst before first valid sync edge");
   a_sel_ground: assert property (pinsS.stdGrounded |-> !stdSelOe)
      else $error("select pin driven while grounded");
   a_phase_force: assert property (ce && toggleEn && st.toggle && st.outHist[1]
      && !pinsS.stdSelIn && !validEdge |=> !st.toggle)
      else $error("pulled select pin did not reverse phase");
   a_ntsc_hold: assert property (!st.palMode |-> !stdSelOe)
      else $error("select pin driven in ntsc");
   a_ext_follow: assert property (ce && pinsS.flagDriven
      |=> burstGate == $past(pinsS.flagIn))
      else $error("burst does not follow external flag");
   a_flag_low: assert property (ce && pinsS.flagDriven && !pinsS.flagIn |=> !burstGate)
      else $error("burst while flag held low");
   a_pal_phase: assert property (burstGate && st.palMode
      |-> envOut.ryOn && (envOut.ryNeg == !st.toggle))
      else $error("pal r-y envelope wrong");
   a_ntsc_byonly: assert property (burstGate && !st.palMode |-> !envOut.ryOn)
      else $error("ntsc r-y envelope present");
   a_toggle_line: assert property (ce && validEdge && toggleEn && pinsS.stdSelIn
      |=> st.toggle != $past(st.toggle))
      else $error("half line toggle did not flip");

   c_ntsc_burst: cover property ($rose(burstGate) && !st.palMode && !pinsS.flagDriven);
   c_pal_burst: cover property ($rose(burstGate) && st.palMode && !pinsS.flagDriven);
   c_phase_force: cover property (ce && toggleEn && st.toggle && !pinsS.stdSelIn);
   c_ext_flag: cover property (pinsS.flagDriven && $rose(burstGate));
   c_pal_mode: cover property ($rose(st.palMode));
endmodule // cbg_sequencer

/* logic/cbg_pkg.sv */
// constants and carrier types of the colour burst gate sequencer
// assumes mclk is the subcarrier clock from the quadrature divider
package cbg_pkg;
   localparam int CNT_W = 9;
   localparam logic [CNT_W-1:0] CNT_MAX = 9'h1ff;
   localparam logic [CNT_W-1:0] CNT_ZERO = 9'h000;
   localparam logic [CNT_W-1:0] CNT_ONE = 9'h001;
   localparam int DIV256_BIT = 8;
   // burst window, in subcarrier counts after the sampled sync edge
   localparam logic [CNT_W-1:0] NTSC_START = 9'h012;
   localparam logic [CNT_W-1:0] NTSC_LEN = 9'h009;
   localparam logic [CNT_W-1:0] PAL_START = 9'h018;
   localparam logic [CNT_W-1:0] PAL_LEN = 9'h00a;
   // half a line interval, in subcarrier counts
   localparam logic [CNT_W-1:0] NTSC_HALF = 9'h072;
   localparam logic [CNT_W-1:0] PAL_HALF = 9'h08e;
   localparam logic TOGGLE_RST = 1'b0;
   localparam int PIN_W = 5;

   typedef struct packed {
      logic syncIn;
      logic flagIn;
      logic flagDriven;
      logic stdSelIn;
      logic stdGrounded;
   } cbg_pins_t;

   typedef struct packed {
      logic byNeg;
      logic ryOn;
      logic ryNeg;
   } cbg_env_t;

   localparam cbg_pins_t PINS_RST = 5'h00;
   localparam cbg_env_t ENV_RST = 3'h0;
endpackage

/* logic/cbg_sync2.sv */
// two-flop synchroniser for a group of pin levels
// assumes inputs are asynchronous to mclk
`timescale 1ns/1ps
module cbg_sync2 (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic ce,
   input wire cbg_pkg::cbg_pins_t pinsIn,
   output cbg_pkg::cbg_pins_t pinsOut
);
   import cbg_pkg::*;

   typedef struct packed {
      cbg_pins_t meta;
      cbg_pins_t stable;
   } cbg_sync_state_t;

   cbg_sync_state_t st;
   cbg_sync_state_t next_st;

   always_comb begin
      next_st = st;
      if (ce) begin
         next_st.meta = pinsIn;
         next_st.stable = st.meta;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         st <= {PINS_RST, PINS_RST};
      end else begin
         st <= next_st;
      end
   end

   assign pinsOut = st.stable;
endmodule // cbg_sync2

/* bench/cbg_src_model.sv */
// sync source and burst flag driver model
// assumes mclk is the subcarrier clock
`timescale 1ns/1ps
module cbg_src_model (
   input wire logic mclk,
   input wire logic [8:0] lineLen,
   input wire logic [1:0] flagMode,
   output logic syncIn = 1'b0,
   output logic flagIn = 1'b0,
   output logic flagDriven = 1'b0
);
   logic [8:0] cnt = 9'h000;
   always @(posedge mclk) begin
      cnt <= (cnt >= lineLen - 9'h001) ? 9'h000 : cnt + 9'h001;
      syncIn <= cnt < 9'h010;
      flagIn <= flagMode == 2'h1 && cnt >= 9'h028 && cnt < 9'h034;
      flagDriven <= flagMode != 2'h0;
   end
endmodule // cbg_src_model

/* bench/color_burst_gate_sequencer_test.sv */
// self-checking bench of the burst gate sequencer
// assumes the source model drives sync and flag pins
`timescale 1ns/1ps
module color_burst_gate_sequencer_test;
   import cbg_pkg::*;
   logic mclk = 1'b0;
   logic arst_n = 1'b0;
   logic stdGrounded = 1'b1;
   logic pullLow = 1'b0;
   logic [8:0] lineLen = 9'h0e4;
   logic [1:0] flagMode = 2'h0;
   logic syncIn, flagIn, flagDriven, stdSelIn, stdSelOut, stdSelOe, burstGate, palMode;
   cbg_env_t envOut, env;
   int n_errors = 0;
   int compares = 0;
   int d, len;
   always #5 mclk = ~mclk;
   // pad level: grounded or pulled low, driven, else pulled up
   assign stdSelIn = !stdGrounded & !pullLow & (stdSelOe ? stdSelOut : 1'b1);
   cbg_src_model u_src (.mclk(mclk), .lineLen(lineLen), .flagMode(flagMode),
      .syncIn(syncIn), .flagIn(flagIn), .flagDriven(flagDriven));
   cbg_sequencer u_dut (.mclk(mclk), .arst_n(arst_n), .ce(1'b1), .syncIn(syncIn),
      .flagIn(flagIn), .flagDriven(flagDriven), .stdSelIn(stdSelIn),
      .stdGrounded(stdGrounded), .stdSelOut(stdSelOut), .stdSelOe(stdSelOe),
      .burstGate(burstGate), .envOut(envOut), .palMode(palMode));
   task automatic report_and_stop;
      if (n_errors == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(int got, int exp, int slack);
      compares++;
      if (got < exp - slack || got > exp + slack) begin
         n_errors++;
         $display("BAD %0t count %0d want %0d", $time, got, exp);
      end
   endtask
   task automatic chkb(logic got, logic exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %0t flag %b want %b", $time, got, exp);
      end
   endtask
   // delay from sync rise to gate, gate length
   task automatic measure;
      int i;
      d = 0;
      len = 0;
      for (i = 0; i < 600 && syncIn === 1'b1; i++) @(negedge mclk);
      for (; i < 600 && syncIn !== 1'b1; i++) @(negedge mclk);
      while (burstGate !== 1'b1 && d < 100) begin d++; @(negedge mclk); end
      env = envOut;
      while (burstGate === 1'b1 && len < 100) begin len++; @(negedge mclk); end
      if (i >= 600 || d >= 100) begin
         n_errors++;
         report_and_stop();
      end
   endtask
   task automatic ntsc_case;
      repeat (3) measure();
      chk(d, int'(NTSC_START) + 3, 1);
      chk(len, int'(NTSC_LEN), 0);
      chkb(env.byNeg, 1'b1);
      chkb(env.ryOn, 1'b0);
      chkb(palMode, 1'b0);
      chkb(stdSelOe, 1'b0);
   endtask
   task automatic pal_case;
      logic prev;
      int k;
      @(posedge mclk);
      stdGrounded <= 1'b0;
      lineLen <= 9'h11c;
      repeat (4) measure();
      prev = env.ryNeg;
      measure();
      chk(d, int'(PAL_START) + 3, 1);
      chk(len, int'(PAL_LEN), 0);
      chkb(env.byNeg & env.ryOn, 1'b1);
      chkb(env.ryNeg, !prev);
      chkb(stdSelOut, !env.ryNeg);
      chkb(stdSelOe, 1'b1);
      chkb(palMode, 1'b1);
      for (k = 0; k < 2 && stdSelOut !== 1'b1; k++) measure();
      @(posedge mclk);
      pullLow <= 1'b1;
      @(posedge mclk);
      pullLow <= 1'b0;
      repeat (5) @(negedge mclk);
      chkb(stdSelOut, 1'b0);
      measure();
      chkb(env.ryNeg, 1'b0);
   endtask
   task automatic ext_case;
      int i;
      @(posedge mclk);
      flagMode <= 2'h1;
      repeat (2) measure();
      chk(d, 43, 1);
      chk(len, 12, 0);
      @(posedge mclk);
      flagMode <= 2'h2;
      repeat (10) @(negedge mclk);
      len = 0;
      for (i = 0; i < 600; i++) begin
         @(negedge mclk);
         len += int'(burstGate !== 1'b0);
      end
      chk(len, 0, 0);
   endtask
   initial begin
      repeat (4) @(posedge mclk);
      arst_n <= 1'b1;
      ntsc_case();
      pal_case();
      ext_case();
      report_and_stop();
   end
endmodule // color_burst_gate_sequencer_test
